//--- logic/agd_pkg.sv
// Constants and types for the address generation and data transfer unit
package agd_pkg;

	localparam int AGD_ADDR_W = 20;
	localparam int AGD_DATA_W = 16;

	// General register indices (word view); byte view uses 0-3 low, 4-7 high
	localparam logic [2:0] AGD_R_ACC = 3'h0;
	localparam logic [2:0] AGD_R_DATA_D = 3'h2;
	localparam logic [2:0] AGD_R_BASE_B = 3'h3;
	localparam logic [2:0] AGD_R_STACK_PTR = 3'h4;
	localparam logic [2:0] AGD_R_FRAME_BASE = 3'h5;
	localparam logic [2:0] AGD_R_SRC_INDEX = 3'h6;
	localparam logic [2:0] AGD_R_DEST_INDEX = 3'h7;

	// Segment register indices
	localparam logic [1:0] AGD_S_EXTRA = 2'h0;
	localparam logic [1:0] AGD_S_CODE = 2'h1;
	localparam logic [1:0] AGD_S_STACK = 2'h2;
	localparam logic [1:0] AGD_S_DATA = 2'h3;

	// Values after reset: code_segment:instr_pointer lands at FFFF0H
	localparam logic [15:0] AGD_RST_CODE_SEG = 16'hFFFF;
	localparam logic [15:0] AGD_RST_IP = 16'h0000;
	localparam logic [19:0] AGD_RESET_FETCH_ADDR = 20'hFFFF0;
	localparam logic [15:0] AGD_RST_FLAGS = 16'h0000;

	// Stack word step, vector entry size and its shift, pointer high word offset
	localparam logic [15:0] AGD_STACK_STEP = 16'h0002;
	localparam int AGD_VEC_SHIFT = 2;
	localparam logic [19:0] AGD_HI_WORD_OFS = 20'h00002;
	// Flag bits loaded from acc high byte: sign, zero, aux, parity, carry
	localparam logic [7:0] AGD_AH_FLAG_MASK = 8'hD5;

	// View select codes
	localparam logic [3:0] AGD_VIEW_SEG0 = 4'h8;
	localparam logic [3:0] AGD_VIEW_IP = 4'hC;
	localparam logic [3:0] AGD_VIEW_FLAGS = 4'hD;

	typedef enum logic [3:0] {
		AGD_OP_NOP = 4'b0000,
		AGD_OP_MOVE = 4'b0001,
		AGD_OP_PUSH = 4'b0010,
		AGD_OP_POP = 4'b0011,
		AGD_OP_EXCHANGE = 4'b0100,
		AGD_OP_PORT_READ = 4'b0101,
		AGD_OP_PORT_WRITE = 4'b0110,
		AGD_OP_TABLE_XLATE = 4'b0111,
		AGD_OP_LOAD_OFFSET = 4'b1000,
		AGD_OP_LOAD_PTR_DS = 4'b1001,
		AGD_OP_LOAD_PTR_ES = 4'b1010,
		AGD_OP_FLAGS_FROM_AH = 4'b1011,
		AGD_OP_POP_FLAGS = 4'b1100,
		AGD_OP_VECTOR = 4'b1101,
		AGD_OP_FETCH = 4'b1110
	} agd_op_t;

	typedef enum logic [1:0] {
		AGD_ST_IDLE = 2'b00,
		AGD_ST_READ = 2'b01,
		AGD_ST_READ_HI = 2'b10,
		AGD_ST_WRITE = 2'b11
	} agd_state_t;

endpackage : agd_pkg

//--- logic/agd_xfer.sv
// Address generation and data transfer execution unit
`timescale 1ns/1ps
module agd_xfer
	import agd_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_start,
	input wire agd_op_t i_op,
	input wire logic i_word,
	input wire logic i_dir,
	input wire logic [1:0] i_mod,
	input wire logic [2:0] i_rm,
	input wire logic [2:0] i_reg,
	input wire logic i_seg_operand,
	input wire logic [15:0] i_disp,
	input wire logic i_seg_ovr_en,
	input wire logic [1:0] i_seg_ovr,
	input wire logic [7:0] i_port,
	input wire logic i_port_var,
	input wire logic [7:0] i_vec_type,
	input wire logic [3:0] i_view_sel,
	input wire logic i_bus_ack,
	input wire logic [15:0] i_bus_rdata,
	output logic o_busy,
	output logic o_done,
	output logic o_fault,
	output logic [7:0] o_fetch_data,
	output logic [15:0] o_view_data,
	output logic o_bus_req,
	output logic o_bus_we,
	output logic o_bus_io,
	output logic o_bus_word,
	output logic [19:0] o_bus_addr,
	output logic [15:0] o_bus_wdata
);

	typedef struct packed {
		agd_state_t state;
		agd_op_t op;
		logic [7:0][15:0] gpr;
		logic [3:0][15:0] seg;
		logic [15:0] ip;
		logic [15:0] flags;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic we;
		logic io;
		logic word;
		logic [2:0] dst;
		logic seg_opnd;
		logic [15:0] tmp;
		logic [7:0] fetch_data;
		logic done;
		logic fault;
		logic [15:0] view;
	} agd_regs_t;

	agd_regs_t s_reg;
	agd_regs_t s_next;

	function automatic logic [15:0] rd_reg(input logic [7:0][15:0] g, input logic [2:0] idx,
		input logic word);
		if (word)
		begin
			rd_reg = g[idx];
		end
		else if (idx[2])
		begin
			rd_reg = {8'h00, g[{1'b0, idx[1:0]}][15:8]};
		end
		else
		begin
			rd_reg = {8'h00, g[{1'b0, idx[1:0]}][7:0]};
		end
	endfunction : rd_reg

	function automatic logic [7:0][15:0] wr_reg(input logic [7:0][15:0] g,
		input logic [2:0] idx, input logic word, input logic [15:0] val);
		wr_reg = g;
		if (word)
		begin
			wr_reg[idx] = val;
		end
		else if (idx[2])
		begin
			wr_reg[{1'b0, idx[1:0]}][15:8] = val[7:0];
		end
		else
		begin
			wr_reg[{1'b0, idx[1:0]}][7:0] = val[7:0];
		end
	endfunction : wr_reg

	// Offset of a memory operand
	function automatic logic [15:0] ea_calc(input logic [7:0][15:0] g, input logic [1:0] md,
		input logic [2:0] rm, input logic [15:0] disp);
		logic [15:0] base;
		logic [15:0] d;
		base = 16'h0000;
		d = 16'h0000;
		case (md)
			2'h1: d = {{8{disp[7]}}, disp[7:0]};
			2'h2: d = disp;
			default: d = 16'h0000;
		endcase
		case (rm)
			3'h0: base = g[AGD_R_BASE_B] + g[AGD_R_SRC_INDEX];
			3'h1: base = g[AGD_R_BASE_B] + g[AGD_R_DEST_INDEX];
			3'h2: base = g[AGD_R_FRAME_BASE] + g[AGD_R_SRC_INDEX];
			3'h3: base = g[AGD_R_FRAME_BASE] + g[AGD_R_DEST_INDEX];
			3'h4: base = g[AGD_R_SRC_INDEX];
			3'h5: base = g[AGD_R_DEST_INDEX];
			3'h6: base = (md == 2'h0) ? 16'h0000 : g[AGD_R_FRAME_BASE];
			default: base = g[AGD_R_BASE_B];
		endcase
		if (md == 2'h0 && rm == 3'h6)
		begin
			d = disp;
		end
		ea_calc = base + d;
	endfunction : ea_calc

	// Segment for a data operand; without an override, frame_base_reg forms go to the stack segment
	function automatic logic [1:0] seg_pick(input logic [1:0] md, input logic [2:0] rm,
		input logic ovr_en, input logic [1:0] ovr);
		logic bp_based;
		bp_based = (rm == 3'h2) || (rm == 3'h3) || (rm == 3'h6 && md != 2'h0);
		if (ovr_en)
		begin
			seg_pick = ovr;
		end
		else if (bp_based)
		begin
			seg_pick = AGD_S_STACK;
		end
		else
		begin
			seg_pick = AGD_S_DATA;
		end
	endfunction : seg_pick

	// Carry out of bit 19 is dropped, so addresses wrap at the top of memory
	function automatic logic [19:0] phys(input logic [15:0] sb, input logic [15:0] ofs);
		phys = {sb, 4'h0} + {4'h0, ofs};
	endfunction : phys

	always_comb
	begin
		logic [15:0] ea;
		logic [15:0] regval;
		logic [15:0] sp_dec;
		logic [1:0] ds;
		logic mem_opnd;
		ea = ea_calc(s_reg.gpr, i_mod, i_rm, i_disp);
		regval = i_seg_operand ? s_reg.seg[i_reg[1:0]] : rd_reg(s_reg.gpr, i_reg, i_word);
		sp_dec = s_reg.gpr[AGD_R_STACK_PTR] - AGD_STACK_STEP;
		ds = seg_pick(i_mod, i_rm, i_seg_ovr_en, i_seg_ovr);
		mem_opnd = (i_mod != 2'h3);
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.fault = 1'b0;
		case (s_reg.state)
			AGD_ST_IDLE:
			begin
				if (i_start)
				begin
					s_next.op = i_op;
					s_next.dst = i_reg;
					s_next.word = i_word;
					s_next.seg_opnd = i_seg_operand;
					s_next.we = 1'b0;
					s_next.io = 1'b0;
					s_next.addr = phys(s_reg.seg[ds], ea);
					s_next.wdata = regval;
					s_next.done = 1'b1;
					if (i_seg_operand && !(i_op == AGD_OP_MOVE || i_op == AGD_OP_PUSH
						|| i_op == AGD_OP_POP))
					begin
						// A refused operation reports only the fault, never completion
						s_next.done = 1'b0;
						s_next.fault = 1'b1;
					end
					else
					begin
						case (i_op)
							AGD_OP_MOVE:
							begin
								if (!mem_opnd && i_seg_operand)
								begin
									if (i_dir)
									begin
										s_next.seg[i_reg[1:0]] = s_reg.gpr[i_rm];
									end
									else
									begin
										s_next.gpr = wr_reg(s_reg.gpr, i_rm, 1'b1, regval);
									end
								end
								else if (!mem_opnd)
								begin
									if (i_dir)
									begin
										s_next.gpr = wr_reg(s_reg.gpr, i_reg, i_word,
											rd_reg(s_reg.gpr, i_rm, i_word));
									end
									else
									begin
										s_next.gpr = wr_reg(s_reg.gpr, i_rm, i_word, regval);
									end
								end
								else
								begin
									s_next.done = 1'b0;
									s_next.we = !i_dir;
									s_next.word = i_word | i_seg_operand;
									s_next.state = i_dir ? AGD_ST_READ : AGD_ST_WRITE;
								end
							end
							AGD_OP_PUSH:
							begin
								s_next.done = 1'b0;
								s_next.gpr[AGD_R_STACK_PTR] = sp_dec;
								s_next.addr = phys(s_reg.seg[AGD_S_STACK], sp_dec);
								s_next.wdata = i_seg_operand ? regval : s_reg.gpr[i_reg];
								s_next.word = 1'b1;
								s_next.we = 1'b1;
								s_next.state = AGD_ST_WRITE;
							end
							AGD_OP_POP, AGD_OP_POP_FLAGS:
							begin
								s_next.done = 1'b0;
								s_next.addr = phys(s_reg.seg[AGD_S_STACK],
									s_reg.gpr[AGD_R_STACK_PTR]);
								s_next.word = 1'b1;
								s_next.state = AGD_ST_READ;
							end
							AGD_OP_EXCHANGE:
							begin
								if (mem_opnd)
								begin
									s_next.done = 1'b0;
									s_next.state = AGD_ST_READ;
								end
								else
								begin
									s_next.gpr = wr_reg(wr_reg(s_reg.gpr, i_rm, i_word, regval),
										i_reg, i_word, rd_reg(s_reg.gpr, i_rm, i_word));
								end
							end
							AGD_OP_PORT_READ, AGD_OP_PORT_WRITE:
							begin
								s_next.done = 1'b0;
								s_next.io = 1'b1;
								s_next.addr = {4'h0, i_port_var ? s_reg.gpr[AGD_R_DATA_D]
									: {8'h00, i_port}};
								s_next.wdata = rd_reg(s_reg.gpr, AGD_R_ACC, i_word);
								s_next.we = (i_op == AGD_OP_PORT_WRITE);
								s_next.state = (i_op == AGD_OP_PORT_WRITE) ? AGD_ST_WRITE
									: AGD_ST_READ;
							end
							AGD_OP_TABLE_XLATE:
							begin
								s_next.done = 1'b0;
								s_next.word = 1'b0;
								s_next.addr = phys(s_reg.seg[i_seg_ovr_en ? i_seg_ovr : AGD_S_DATA],
									s_reg.gpr[AGD_R_BASE_B]
									+ {8'h00, s_reg.gpr[AGD_R_ACC][7:0]});
								s_next.state = AGD_ST_READ;
							end
							AGD_OP_LOAD_OFFSET:
							begin
								if (mem_opnd)
								begin
									s_next.gpr = wr_reg(s_reg.gpr, i_reg, 1'b1, ea);
								end
								else
								begin
									s_next.done = 1'b0;
									s_next.fault = 1'b1;
								end
							end
							AGD_OP_LOAD_PTR_DS, AGD_OP_LOAD_PTR_ES:
							begin
								if (mem_opnd)
								begin
									s_next.done = 1'b0;
									s_next.word = 1'b1;
									s_next.state = AGD_ST_READ;
								end
								else
								begin
									s_next.done = 1'b0;
									s_next.fault = 1'b1;
								end
							end
							AGD_OP_FLAGS_FROM_AH:
							begin
								s_next.flags[7:0] = (s_reg.flags[7:0] & ~AGD_AH_FLAG_MASK)
									| (s_reg.gpr[AGD_R_ACC][15:8] & AGD_AH_FLAG_MASK);
							end
							AGD_OP_VECTOR:
							begin
								s_next.done = 1'b0;
								s_next.word = 1'b1;
								s_next.addr = {10'h000, i_vec_type, 2'h0};
								s_next.state = AGD_ST_READ;
							end
							AGD_OP_FETCH:
							begin
								s_next.done = 1'b0;
								s_next.word = 1'b0;
								s_next.addr = phys(s_reg.seg[AGD_S_CODE], s_reg.ip);
								s_next.state = AGD_ST_READ;
							end
							default:
							begin
								s_next.done = 1'b1;
							end
						endcase
					end
				end
			end
			AGD_ST_READ:
			begin
				if (i_bus_ack)
				begin
					s_next.state = AGD_ST_IDLE;
					s_next.done = 1'b1;
					case (s_reg.op)
						AGD_OP_MOVE, AGD_OP_POP:
						begin
							if (s_reg.seg_opnd)
							begin
								s_next.seg[s_reg.dst[1:0]] = i_bus_rdata;
							end
							else
							begin
								s_next.gpr = wr_reg(s_reg.gpr, s_reg.dst, s_reg.word, i_bus_rdata);
							end
							if (s_reg.op == AGD_OP_POP)
							begin
								s_next.gpr[AGD_R_STACK_PTR] = s_reg.gpr[AGD_R_STACK_PTR]
									+ AGD_STACK_STEP;
							end
						end
						AGD_OP_POP_FLAGS:
						begin
							s_next.flags = i_bus_rdata;
							s_next.gpr[AGD_R_STACK_PTR] = s_reg.gpr[AGD_R_STACK_PTR]
								+ AGD_STACK_STEP;
						end
						AGD_OP_EXCHANGE:
						begin
							// Old register value, captured at start, goes back to memory
							s_next.gpr = wr_reg(s_reg.gpr, s_reg.dst, s_reg.word, i_bus_rdata);
							s_next.we = 1'b1;
							s_next.done = 1'b0;
							s_next.state = AGD_ST_WRITE;
						end
						AGD_OP_PORT_READ:
						begin
							s_next.gpr = wr_reg(s_reg.gpr, AGD_R_ACC, s_reg.word, i_bus_rdata);
						end
						AGD_OP_TABLE_XLATE:
						begin
							s_next.gpr[AGD_R_ACC][7:0] = i_bus_rdata[7:0];
						end
						AGD_OP_FETCH:
						begin
							s_next.fetch_data = i_bus_rdata[7:0];
							s_next.ip = s_reg.ip + 16'h0001;
						end
						default:
						begin
							// Pointer and vector loads: low word is the offset
							s_next.tmp = i_bus_rdata;
							s_next.addr = s_reg.addr + AGD_HI_WORD_OFS;
							s_next.done = 1'b0;
							s_next.state = AGD_ST_READ_HI;
						end
					endcase
				end
			end
			AGD_ST_READ_HI:
			begin
				if (i_bus_ack)
				begin
					s_next.state = AGD_ST_IDLE;
					s_next.done = 1'b1;
					case (s_reg.op)
						AGD_OP_LOAD_PTR_DS:
						begin
							s_next.seg[AGD_S_DATA] = i_bus_rdata;
							s_next.gpr[s_reg.dst] = s_reg.tmp;
						end
						AGD_OP_LOAD_PTR_ES:
						begin
							s_next.seg[AGD_S_EXTRA] = i_bus_rdata;
							s_next.gpr[s_reg.dst] = s_reg.tmp;
						end
						default:
						begin
							s_next.seg[AGD_S_CODE] = i_bus_rdata;
							s_next.ip = s_reg.tmp;
						end
					endcase
				end
			end
			default:
			begin
				if (i_bus_ack)
				begin
					s_next.state = AGD_ST_IDLE;
					s_next.we = 1'b0;
					s_next.done = 1'b1;
				end
			end
		endcase
		if (i_view_sel < AGD_VIEW_SEG0)
		begin
			s_next.view = s_next.gpr[i_view_sel[2:0]];
		end
		else if (i_view_sel < AGD_VIEW_IP)
		begin
			s_next.view = s_next.seg[i_view_sel[1:0]];
		end
		else if (i_view_sel == AGD_VIEW_IP)
		begin
			s_next.view = s_next.ip;
		end
		else if (i_view_sel == AGD_VIEW_FLAGS)
		begin
			s_next.view = s_next.flags;
		end
		else
		begin
			s_next.view = 16'h0000;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			s_reg <= '0;
			s_reg.op <= AGD_OP_FETCH;
			s_reg.state <= AGD_ST_READ;
			s_reg.seg[AGD_S_CODE] <= AGD_RST_CODE_SEG;
			s_reg.ip <= AGD_RST_IP;
			s_reg.flags <= AGD_RST_FLAGS;
			s_reg.addr <= AGD_RESET_FETCH_ADDR;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign o_busy = (s_reg.state != AGD_ST_IDLE);
	assign o_done = s_reg.done;
	assign o_fault = s_reg.fault;
	assign o_fetch_data = s_reg.fetch_data;
	assign o_view_data = s_reg.view;
	assign o_bus_req = (s_reg.state != AGD_ST_IDLE);
	assign o_bus_we = s_reg.we;
	assign o_bus_io = s_reg.io;
	assign o_bus_word = s_reg.word;
	assign o_bus_addr = s_reg.addr;
	assign o_bus_wdata = s_reg.wdata;

endmodule : agd_xfer

//--- testbench/agd_xfer_monitor.sv
// Port-level assertions for the transfer unit
`timescale 1ns/1ps
module agd_xfer_monitor
	import agd_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_start,
	input wire agd_op_t i_op,
	input wire logic [1:0] i_mod,
	input wire logic i_seg_operand,
	input wire logic [7:0] i_port,
	input wire logic i_port_var,
	input wire logic [7:0] i_vec_type,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_fault,
	input wire logic o_bus_req,
	input wire logic o_bus_we,
	input wire logic o_bus_io,
	input wire logic o_bus_word,
	input wire logic [19:0] o_bus_addr
);
	logic go;
	// A start while busy is ignored, so only accepted starts count
	assign go = i_start && !o_busy;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	a_reset_fetch: assert property ($fell(i_srst) |->
		o_bus_req && !o_bus_we && !o_bus_io && o_bus_addr == AGD_RESET_FETCH_ADDR)
		else $error("first fetch after reset misplaced");
	a_seg_refuse: assert property (go && i_seg_operand &&
		!(i_op inside {AGD_OP_MOVE, AGD_OP_PUSH, AGD_OP_POP}) |=> o_fault && !o_done && !o_bus_req)
		else $error("segment operand accepted");
	a_push_write: assert property (go && i_op == AGD_OP_PUSH |=>
		o_bus_req && o_bus_we && o_bus_word && !o_bus_io)
		else $error("push is not a word write");
	a_pop_read: assert property (go && i_op == AGD_OP_POP |=>
		o_bus_req && !o_bus_we && o_bus_word)
		else $error("pop is not a word read");
	a_port_fixed: assert property (go && i_op == AGD_OP_PORT_READ && !i_port_var |=>
		o_bus_req && o_bus_io && !o_bus_we && o_bus_addr == {12'h000, $past(i_port)})
		else $error("inline port address wrong");
	a_port_write: assert property (go && i_op == AGD_OP_PORT_WRITE |=>
		o_bus_req && o_bus_io && o_bus_we)
		else $error("port write not an io write");
	a_vector_slot: assert property (go && i_op == AGD_OP_VECTOR |=>
		o_bus_req && !o_bus_io && o_bus_addr == {10'h000, $past(i_vec_type), 2'b00})
		else $error("vector entry address wrong");
	a_offset_nobus: assert property (go && i_op == AGD_OP_LOAD_OFFSET &&
		i_mod != 2'h3 && !i_seg_operand |=> o_done && !o_bus_req)
		else $error("offset load touched the bus");
	a_table_translate_op_byte: assert property (go && i_op == AGD_OP_TABLE_XLATE |=>
		o_bus_req && !o_bus_we && !o_bus_word && !o_bus_io)
		else $error("table lookup not a byte read");
	cover property (go && i_op == AGD_OP_PUSH);
	cover property (o_fault);
	cover property (go && i_op == AGD_OP_LOAD_PTR_DS);
	cover property (go && i_op == AGD_OP_POP_FLAGS);
endmodule : agd_xfer_monitor

bind agd_xfer agd_xfer_monitor u_mon (.i_ref_clk, .i_srst, .i_start, .i_op, .i_mod,
	.i_seg_operand, .i_port, .i_port_var, .i_vec_type, .o_busy, .o_done, .o_fault,
	.o_bus_req, .o_bus_we, .o_bus_io, .o_bus_word, .o_bus_addr);

//--- testbench/agd_mem_model.sv
// Behavioural memory and port space answering the unit's bus
`timescale 1ns/1ps
module agd_mem_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_dly,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic i_io,
	input wire logic i_word,
	input wire logic [19:0] i_addr,
	input wire logic [15:0] i_wdata,
	output logic o_ack,
	output logic [15:0] o_rdata
);
	logic [7:0] m [int];
	int cnt = 0;
	int k;
	function automatic logic [7:0] rb(int a);
		return m.exists(a) ? m[a] : 8'hA5;
	endfunction : rb
	// Port space sits above memory in one key range
	assign k = {i_io, i_addr};
	initial
	begin
		o_ack = 1'b0;
		o_rdata = 16'h0000;
	end
	// Data lines toggle outside an answer so stale values never look valid
	always @(posedge i_clk)
	begin
		if (i_rst || o_ack)
		begin
			o_ack <= 1'b0;
			cnt <= 0;
			o_rdata <= ~o_rdata;
			if (o_ack && i_we)
			begin
				m[k] = i_wdata[7:0];
				if (i_word)
					m[k + 1] = i_wdata[15:8];
			end
		end
		else if (i_req && cnt >= int'(i_dly))
		begin
			o_ack <= 1'b1;
			o_rdata <= {i_word ? rb(k + 1) : ~rb(k), rb(k)};
		end
		else
		begin
			cnt <= i_req ? cnt + 1 : 0;
			o_rdata <= ~o_rdata;
		end
	end
endmodule : agd_mem_model

//--- testbench/agd_xfer_tb.sv
// Self-checking bench for the transfer unit
`timescale 1ns/1ps
module agd_xfer_tb
	import agd_pkg::*;
;
	logic i_ref_clk = 1'b0, i_srst = 1'b1, i_start = 1'b0, i_word = 1'b0, i_dir = 1'b0;
	logic i_seg_operand = 1'b0, i_seg_ovr_en = 1'b0, i_port_var = 1'b0;
	agd_op_t i_op = AGD_OP_NOP;
	logic [1:0] i_mod = 2'h0, i_seg_ovr = 2'h0;
	logic [2:0] i_rm = 3'h0, i_reg = 3'h0;
	logic [15:0] i_disp = 16'h0000;
	logic [7:0] i_port = 8'h00, i_vec_type = 8'h00;
	logic [3:0] i_view_sel = 4'h0, dly = 4'h0;
	logic i_bus_ack, o_busy, o_done, o_fault, o_bus_req, o_bus_we, o_bus_io, o_bus_word;
	logic [15:0] i_bus_rdata, o_view_data, o_bus_wdata;
	logic [7:0] o_fetch_data;
	logic [19:0] o_bus_addr;
	int n_errors = 0;
	int tests_run = 0;
	int n;
	logic f;
	always #20 i_ref_clk = ~i_ref_clk;
	agd_xfer dut (.i_ref_clk, .i_srst, .i_start, .i_op, .i_word, .i_dir, .i_mod, .i_rm, .i_reg,
		.i_seg_operand, .i_disp, .i_seg_ovr_en, .i_seg_ovr, .i_port, .i_port_var, .i_vec_type,
		.i_view_sel, .i_bus_ack, .i_bus_rdata, .o_busy, .o_done, .o_fault, .o_fetch_data,
		.o_view_data, .o_bus_req, .o_bus_we, .o_bus_io, .o_bus_word, .o_bus_addr, .o_bus_wdata);
	agd_mem_model mm (.i_clk(i_ref_clk), .i_rst(i_srst), .i_dly(dly), .i_req(o_bus_req),
		.i_we(o_bus_we), .i_io(o_bus_io), .i_word(o_bus_word), .i_addr(o_bus_addr),
		.i_wdata(o_bus_wdata), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));
	task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	task automatic wdone();
		n = 0;
		#1;
		while (o_done !== 1'b1 && o_fault !== 1'b1)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
			if (n > 40)
			begin
				chk("timeout", 1'b1, 1'b0);
				give_verdict();
			end
		end
		f = o_fault;
	endtask : wdone
	task automatic go(agd_op_t o, logic w, logic d, logic [1:0] md, logic [2:0] rm,
		logic [2:0] rg, logic sg, logic [15:0] dp, logic [2:0] ov);
		@(posedge i_ref_clk);
		i_op <= o;
		i_word <= w;
		i_dir <= d;
		i_port_var <= d;
		i_mod <= md;
		i_rm <= rm;
		i_reg <= rg;
		i_seg_operand <= sg;
		i_disp <= dp;
		i_port <= dp[7:0];
		i_vec_type <= dp[7:0];
		{i_seg_ovr_en, i_seg_ovr} <= ov;
		i_start <= 1'b1;
		@(posedge i_ref_clk);
		i_start <= 1'b0;
		wdone();
	endtask : go
	task automatic cv(string nm, logic [3:0] s, logic [15:0] e);
		@(posedge i_ref_clk);
		i_view_sel <= s;
		@(posedge i_ref_clk);
		#1;
		chk(nm, o_view_data, e);
	endtask : cv
	// Test data also goes into the low vector area, at 0000CH
	task automatic pk(logic [20:0] a, logic [15:0] d);
		mm.m[a] = d[7:0];
		mm.m[a + 21'h1] = d[15:8];
	endtask : pk
	function automatic logic [15:0] gw(logic [20:0] a);
		return {mm.m[a + 21'h1], mm.m[a]};
	endfunction : gw
	task automatic ld(logic [2:0] r, logic [15:0] v);
		pk(21'h00100, v);
		go(AGD_OP_MOVE, 1'b1, 1'b1, 2'h0, 3'h6, r, 1'b0, 16'h0100, 3'h0);
	endtask : ld
	task automatic sg(logic [1:0] s, logic [15:0] v);
		ld(3'h1, v);
		go(AGD_OP_MOVE, 1'b1, 1'b1, 2'h3, 3'h1, {1'b0, s}, 1'b1, 16'h0000, 3'h0);
	endtask : sg
	task automatic t_move();
		ld(AGD_R_ACC, 16'h1234);
		cv("acc", 4'h0, 16'h1234);
		ld(AGD_R_BASE_B, 16'hFFFF);
		pk(21'h00102, 16'h0077);
		go(AGD_OP_MOVE, 1'b0, 1'b1, 2'h0, 3'h6, 3'h3, 1'b0, 16'h0102, 3'h0);
		cv("byte move", 4'h3, 16'hFF77);
		$display("move done");
	endtask : t_move
	task automatic t_seg();
		sg(AGD_S_STACK, 16'h0200);
		cv("ss", 4'hA, 16'h0200);
		ld(AGD_R_FRAME_BASE, 16'h0184);
		pk(21'h02186, 16'hBEEF);
		pk(21'h00186, 16'h1111);
		go(AGD_OP_MOVE, 1'b1, 1'b1, 2'h1, 3'h6, 3'h2, 1'b0, 16'h0002, 3'h0);
		cv("frame default", 4'h2, 16'hBEEF);
		go(AGD_OP_MOVE, 1'b1, 1'b1, 2'h1, 3'h6, 3'h2, 1'b0, 16'h0002, 3'h7);
		cv("override", 4'h2, 16'h1111);
		sg(AGD_S_EXTRA, 16'hFFFF);
		pk(21'h00110, 16'hCAFE);
		go(AGD_OP_MOVE, 1'b1, 1'b1, 2'h0, 3'h6, 3'h2, 1'b0, 16'h0120, 3'h4);
		cv("wrap", 4'h2, 16'hCAFE);
		$display("segment done");
	endtask : t_seg
	task automatic t_stack();
		ld(AGD_R_STACK_PTR, 16'h0010);
		ld(AGD_R_ACC, 16'h1234);
		@(posedge i_ref_clk);
		dly <= 4'h3;
		go(AGD_OP_PUSH, 1'b1, 1'b0, 2'h3, 3'h0, 3'h0, 1'b0, 16'h0000, 3'h4);
		chk("push mem", gw(21'h0200E), 16'h1234);
		cv("sp push", 4'h4, 16'h000E);
		go(AGD_OP_POP, 1'b1, 1'b0, 2'h3, 3'h0, 3'h3, 1'b0, 16'h0000, 3'h0);
		cv("pop dest", 4'h3, 16'h1234);
		cv("sp pop", 4'h4, 16'h0010);
		go(AGD_OP_PUSH, 1'b1, 1'b0, 2'h3, 3'h0, 3'h2, 1'b1, 16'h0000, 3'h0);
		chk("push seg", gw(21'h0200E), 16'h0200);
		@(posedge i_ref_clk);
		dly <= 4'h0;
		$display("stack done");
	endtask : t_stack
	task automatic t_exchange_op();
		go(AGD_OP_EXCHANGE, 1'b1, 1'b0, 2'h3, 3'h0, 3'h1, 1'b1, 16'h0000, 3'h0);
		chk("exchange_op seg", f, 1'b1);
		pk(21'h00280, 16'hABCD);
		go(AGD_OP_EXCHANGE, 1'b1, 1'b0, 2'h0, 3'h6, 3'h0, 1'b0, 16'h0280, 3'h0);
		cv("exchange_op reg", 4'h0, 16'hABCD);
		chk("exchange_op mem", gw(21'h00280), 16'h1234);
		$display("exchange done");
	endtask : t_exchange_op
	task automatic t_port();
		pk(21'h100042, 16'h5566);
		go(AGD_OP_PORT_READ, 1'b1, 1'b0, 2'h0, 3'h0, 3'h0, 1'b0, 16'h0042, 3'h0);
		cv("in word", 4'h0, 16'h5566);
		ld(AGD_R_DATA_D, 16'h1234);
		pk(21'h101234, 16'h00AA);
		go(AGD_OP_PORT_READ, 1'b0, 1'b1, 2'h0, 3'h0, 3'h0, 1'b0, 16'h0000, 3'h0);
		cv("in byte", 4'h0, 16'h55AA);
		go(AGD_OP_PORT_WRITE, 1'b1, 1'b0, 2'h0, 3'h0, 3'h0, 1'b0, 16'h00F0, 3'h0);
		chk("out", gw(21'h1000F0), 16'h55AA);
		$display("port done");
	endtask : t_port
	task automatic t_addr();
		ld(AGD_R_BASE_B, 16'h0200);
		ld(AGD_R_ACC, 16'h3305);
		pk(21'h00205, 16'h009C);
		go(AGD_OP_TABLE_XLATE, 1'b0, 1'b0, 2'h0, 3'h0, 3'h0, 1'b0, 16'h0000, 3'h0);
		cv("table_translate_op", 4'h0, 16'h339C);
		ld(AGD_R_SRC_INDEX, 16'h0010);
		go(AGD_OP_LOAD_OFFSET, 1'b1, 1'b0, 2'h2, 3'h0, 3'h7, 1'b0, 16'h0100, 3'h0);
		chk("lea no bus", 20'(n), 20'h00000);
		cv("lea", 4'h7, 16'h0310);
		go(AGD_OP_LOAD_OFFSET, 1'b1, 1'b0, 2'h3, 3'h0, 3'h7, 1'b0, 16'h0000, 3'h0);
		chk("lea reg src", f, 1'b1);
		cv("flags kept", 4'hD, 16'h0000);
		ld(AGD_R_ACC, 16'hFF00);
		go(AGD_OP_FLAGS_FROM_AH, 1'b0, 1'b0, 2'h3, 3'h0, 3'h0, 1'b0, 16'h0000, 3'h0);
		cv("flags load", 4'hD, 16'h00D5);
		ld(AGD_R_ACC, 16'h0ED7);
		go(AGD_OP_PUSH, 1'b1, 1'b0, 2'h3, 3'h0, 3'h0, 1'b0, 16'h0000, 3'h0);
		go(AGD_OP_POP_FLAGS, 1'b1, 1'b0, 2'h3, 3'h0, 3'h0, 1'b0, 16'h0000, 3'h0);
		cv("flags pop", 4'hD, 16'h0ED7);
		cv("sp pop_flags_op", 4'h4, 16'h000E);
		$display("address done");
	endtask : t_addr
	task automatic t_ptr();
		pk(21'h0000C, 16'h2468);
		pk(21'h0000E, 16'h1357);
		go(AGD_OP_VECTOR, 1'b1, 1'b0, 2'h0, 3'h0, 3'h0, 1'b0, 16'h0003, 3'h0);
		cv("vec ofs", 4'hC, 16'h2468);
		cv("vec seg", 4'h9, 16'h1357);
		pk(21'h00300, 16'h1357);
		pk(21'h00302, 16'h0400);
		go(AGD_OP_LOAD_PTR_ES, 1'b1, 1'b0, 2'h0, 3'h6, 3'h6, 1'b0, 16'h0300, 3'h0);
		cv("les ofs", 4'h6, 16'h1357);
		cv("les seg", 4'h8, 16'h0400);
		pk(21'h00310, 16'h2468);
		pk(21'h00312, 16'h0500);
		go(AGD_OP_LOAD_PTR_DS, 1'b1, 1'b0, 2'h0, 3'h6, 3'h7, 1'b0, 16'h0310, 3'h0);
		cv("lds ofs", 4'h7, 16'h2468);
		cv("lds seg", 4'hB, 16'h0500);
		pk(21'h159D8, 16'h003C);
		go(AGD_OP_FETCH, 1'b0, 1'b0, 2'h0, 3'h0, 3'h0, 1'b0, 16'h0000, 3'h7);
		chk("fetch op", o_fetch_data, 8'h3C);
		cv("ip step", 4'hC, 16'h2469);
		$display("pointer done");
	endtask : t_ptr
	initial
	begin
		pk(21'h0FFFF0, 16'h00EA);
		repeat (2) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		@(posedge i_ref_clk);
		#1;
		chk("fetch addr", o_bus_addr, AGD_RESET_FETCH_ADDR);
		wdone();
		chk("fetch byte", o_fetch_data, 8'hEA);
		$display("reset done");
		t_move();
		t_seg();
		t_stack();
		t_exchange_op();
		t_port();
		t_addr();
		t_ptr();
		give_verdict();
	end
endmodule : agd_xfer_tb
